/* rtl/modem_cfg.svh */
`ifndef MODEM_CFG_SVH
`define MODEM_CFG_SVH

// Register offsets.
`define ADDR_MODE         8'h01
`define ADDR_CCA          8'h02
`define ADDR_DIV          8'h03
`define ADDR_RX_SIG       8'h04
`define ADDR_RX_LEN_HI    8'h05
`define ADDR_RX_LEN_LO    8'h06
`define ADDR_RECEIVED_SERVICE_BYTE       8'h07
`define ADDR_TX_GAIN      8'h11
`define ADDR_TX_LEN_HI    8'h12
`define ADDR_TX_LEN_LO    8'h13
`define ADDR_LOW_TRIM     8'h14
`define ADDR_HIGH_TRIM    8'h15
`define ADDR_OPT1         8'h1c
`define ADDR_OPT2         8'h1d

// Reset values.
`define RST_BYTE          8'h00
`define RST_MODE          4'h0
`define RST_BIT           1'b0

// Field positions and the saturation base value.
`define DIV_EN_BIT        7
`define DIV_ANT_BIT       6
`define GAIN_SCRAMBLE_BIT 1
`define GAIN_EXT_BIT      0
`define HIGH_CH14_BIT     7
`define HIGH_PAD_BIT      6
`define OPT1_SAT_SIGN     7
`define OPT1_RETRIG_BIT   4
`define OPT1_ALT_BIT      3
`define OPT2_LNA_DLY_BIT  7
`define OPT2_RETRIG_LOW   2
`define SAT_BASE          3'h4

// Timing.
`define CLK_PERIOD_NS     100
`define AGC_STEP_NS       1000
`define AGC_STEP_CYC      ((`AGC_STEP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define US_NS             1000
`define US_CYC            ((`US_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ANT_DWELL_NS      4000
`define ANT_DWELL_CYC     ((`ANT_DWELL_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

/* rtl/modem_pkg.sv */
package modem_pkg;
  typedef logic [7:0] reg_byte_t;
  typedef logic [7:0] reg_addr_t;
  typedef enum logic [1:0] {
    TX_IDLE = 2'b01,
    TX_RUN  = 2'b10
  } tx_state_e;
endpackage

/* rtl/bit_sync.sv */
`timescale 1ns/1ns
`default_nettype none
module bit_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic [WIDTH-1:0] asyncIn,
  output var  logic [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] stage1_ff;

  // Two flops; only the second one is seen by other logic.
  always_ff @(posedge clk)
  begin
    stage1_ff <= asyncIn;
    syncOut   <= stage1_ff;
  end
endmodule
`default_nettype wire

/* rtl/rx_port_clock.sv */
`timescale 1ns/1ns
`default_nettype none
module rx_port_clock (
  input  wire logic linkClk,
  input  wire logic linkReset,
  input  wire logic altMode,
  input  wire logic rxBitStrobe,
  input  wire logic receiveValidIn,
  output var  logic dataBitClock,
  output var  logic receiveValid
);
  wire logic extraPulse;
  wire logic clockPulse;

  // One extra clock follows the end of a packet in the alternate port.
  assign extraPulse = altMode && receiveValid && !receiveValidIn;
  assign clockPulse = rxBitStrobe || extraPulse;

  always_ff @(posedge linkClk)
  begin
    if (linkReset)
    begin
      dataBitClock <= 1'b0;
      receiveValid <= 1'b0;
    end
    else
    begin
      dataBitClock <= clockPulse ^ altMode;
      receiveValid <= receiveValidIn;
    end
  end
endmodule
`default_nettype wire

/* rtl/modem_control_regs.sv */
`timescale 1ns/1ns
`default_nettype none
`include "modem_cfg.svh"
////////////////////////////////////////////////////////////////////////////////
module modem_control_regs
  import modem_pkg::*;
(
  input  wire logic                 refClk,
  input  wire logic                 reset,
  input  wire logic                 regWrEn,
  input  wire modem_pkg::reg_addr_t regAddr,
  input  wire modem_pkg::reg_byte_t regWrData,
  output var  modem_pkg::reg_byte_t regRdData,
  input  wire logic [5:0]           rssiPin,
  input  wire logic                 lnaGainSelectPin,
  input  wire logic                 txRequestPin,
  output var  logic [3:0]           txMode,
  output var  logic                 ccaBusy,
  output var  logic                 antennaSelectPin,
  output var  logic [5:0]           transmitGainSetting,
  output var  logic                 scramblerBypass,
  output var  logic                 transmitLengthExtensionBit,
  output var  logic                 txActive,
  output var  logic [5:0]           lowGainTrim,
  output var  logic [5:0]           highGainTrim,
  output var  logic                 sixDbPadBit,
  output var  logic                 channel14Filter,
  output var  logic [2:0]           saturationThreshold,
  output var  logic                 saturationRetriggerBit,
  output var  logic                 retriggerLowCount,
  output var  logic                 agcDecision,
  input  wire logic                 linkClk,
  input  wire logic                 acqIn,
  input  wire logic                 sfdIn,
  input  wire logic                 shortPreIn,
  input  wire logic                 headerDone,
  input  wire modem_pkg::reg_byte_t hdrSignal,
  input  wire modem_pkg::reg_byte_t hdrService,
  input  wire logic [15:0]          hdrLength,
  input  wire logic                 hdrCrcErr,
  input  wire logic                 rxBitStrobe,
  input  wire logic                 receiveValidIn,
  output var  logic                 dataBitClock,
  output var  logic                 receiveValid
);
  import modem_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // Synchronisers.
  wire logic       linkReset;
  wire logic       altLink;
  wire logic [2:0] statusSync;
  wire logic [7:0] pinSync;
  wire logic       hdrToggleSync;
  logic            hdrToggle_ff;
  logic            optAlt_ff;

  bit_sync #(.WIDTH(1)) u_link_reset (.clk(linkClk), .asyncIn(reset), .syncOut(linkReset));
  bit_sync #(.WIDTH(1)) u_alt_sync (.clk(linkClk), .asyncIn(optAlt_ff), .syncOut(altLink));
  bit_sync #(.WIDTH(3)) u_status_sync (
    .clk     (refClk),
    .asyncIn ({shortPreIn, acqIn, sfdIn}),
    .syncOut (statusSync)
  );
  bit_sync #(.WIDTH(8)) u_pin_sync (
    .clk     (refClk),
    .asyncIn ({txRequestPin, lnaGainSelectPin, rssiPin}),
    .syncOut (pinSync)
  );
  bit_sync #(.WIDTH(1)) u_hdr_sync (.clk(refClk), .asyncIn(hdrToggle_ff), .syncOut(hdrToggleSync));

  //////////////////////////////////////////////////////////////////////////////
  // Link side: header capture and receive data port.
  reg_byte_t   hdrSig_ff;
  reg_byte_t   hdrSer_ff;
  logic [15:0] hdrLen_ff;
  logic        hdrCrc_ff;

  always_ff @(posedge linkClk)
  begin
    if (linkReset)
    begin
      hdrToggle_ff <= 1'b0;
      hdrSig_ff    <= `RST_BYTE;
      hdrSer_ff    <= `RST_BYTE;
      hdrLen_ff    <= 16'h0000;
      hdrCrc_ff    <= `RST_BIT;
    end
    else if (headerDone)
    begin
      hdrToggle_ff <= !hdrToggle_ff;
      hdrSig_ff    <= hdrSignal;
      hdrSer_ff    <= hdrService;
      hdrLen_ff    <= hdrLength;
      hdrCrc_ff    <= hdrCrcErr;
    end
  end

  rx_port_clock u_rx_port (
    .linkClk        (linkClk),
    .linkReset      (linkReset),
    .altMode        (altLink),
    .rxBitStrobe    (rxBitStrobe),
    .receiveValidIn (receiveValidIn),
    .dataBitClock   (dataBitClock),
    .receiveValid   (receiveValid)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Register storage and write decode.
  logic [3:0]  mode_ff;
  reg_byte_t   cca_ff;
  logic [1:0]  div_ff;
  reg_byte_t   txGain_ff;
  reg_byte_t   txLenHi_ff;
  reg_byte_t   txLenLo_ff;
  logic [5:0]  lowTrim_ff;
  reg_byte_t   highTrim_ff;
  logic [2:0]  satOffset_ff;
  logic        optRetrig_ff;
  logic        lnaDly_ff;
  logic        retrigLow_ff;
  reg_byte_t   rxSig_ff;
  reg_byte_t   rxSer_ff;
  logic [15:0] rxLen_ff;
  logic        rxCrc_ff;
  logic        hdrSeen_ff;

  wire logic wrMode   = regWrEn && (regAddr == `ADDR_MODE);
  wire logic wrCca    = regWrEn && (regAddr == `ADDR_CCA);
  wire logic wrDiv    = regWrEn && (regAddr == `ADDR_DIV);
  wire logic wrGain   = regWrEn && (regAddr == `ADDR_TX_GAIN);
  wire logic wrLenHi  = regWrEn && (regAddr == `ADDR_TX_LEN_HI);
  wire logic wrLenLo  = regWrEn && (regAddr == `ADDR_TX_LEN_LO);
  wire logic wrLow    = regWrEn && (regAddr == `ADDR_LOW_TRIM);
  wire logic wrHigh   = regWrEn && (regAddr == `ADDR_HIGH_TRIM);
  wire logic wrOpt1   = regWrEn && (regAddr == `ADDR_OPT1);
  wire logic wrOpt2   = regWrEn && (regAddr == `ADDR_OPT2);
  wire logic hdrEvent = hdrToggleSync ^ hdrSeen_ff;

  wire logic       acquiredFlag   = statusSync[1];
  wire logic       delimiterFlag  = statusSync[0];
  wire logic       shortPreamble  = statusSync[2];
  wire logic [5:0] signalStrength = pinSync[5:0];

  always_ff @(posedge refClk)
  begin
    if (reset)
    begin
      mode_ff      <= `RST_MODE;
      cca_ff       <= `RST_BYTE;
      div_ff       <= 2'b00;
      txGain_ff    <= `RST_BYTE;
      txLenHi_ff   <= `RST_BYTE;
      txLenLo_ff   <= `RST_BYTE;
      lowTrim_ff   <= 6'h00;
      highTrim_ff  <= `RST_BYTE;
      satOffset_ff <= 3'h0;
      optRetrig_ff <= `RST_BIT;
      optAlt_ff    <= `RST_BIT;
      lnaDly_ff    <= `RST_BIT;
      retrigLow_ff <= `RST_BIT;
    end
    else
    begin
      if (wrMode) mode_ff <= regWrData[7:4];
      if (wrCca) cca_ff <= regWrData;
      if (wrDiv) div_ff <= regWrData[7:6];
      if (wrGain) txGain_ff <= regWrData;
      if (wrLenHi) txLenHi_ff <= regWrData;
      if (wrLenLo) txLenLo_ff <= regWrData;
      if (wrLow) lowTrim_ff <= regWrData[5:0];
      if (wrHigh) highTrim_ff <= regWrData;
      if (wrOpt1)
      begin
        satOffset_ff <= regWrData[7:5];
        optRetrig_ff <= regWrData[`OPT1_RETRIG_BIT];
        optAlt_ff    <= regWrData[`OPT1_ALT_BIT];
      end
      if (wrOpt2)
      begin
        lnaDly_ff    <= regWrData[`OPT2_LNA_DLY_BIT];
        retrigLow_ff <= regWrData[`OPT2_RETRIG_LOW];
      end
    end
  end

  // Received header fields, taken once per header from the link side.
  always_ff @(posedge refClk)
  begin
    if (reset)
    begin
      hdrSeen_ff <= 1'b0;
      rxSig_ff   <= `RST_BYTE;
      rxSer_ff   <= `RST_BYTE;
      rxLen_ff   <= 16'h0000;
      rxCrc_ff   <= `RST_BIT;
    end
    else
    begin
      hdrSeen_ff <= hdrToggleSync;
      if (hdrEvent)
      begin
        rxSig_ff <= hdrSig_ff;
        rxSer_ff <= hdrSer_ff;
        rxLen_ff <= hdrLen_ff;
        rxCrc_ff <= hdrCrc_ff;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read path.
  wire reg_byte_t rdMux =
    (regAddr == `ADDR_MODE)      ? {mode_ff, shortPreamble, acquiredFlag, delimiterFlag, rxCrc_ff} :
    (regAddr == `ADDR_CCA)       ? cca_ff :
    (regAddr == `ADDR_DIV)       ? {div_ff, signalStrength} :
    (regAddr == `ADDR_RX_SIG)    ? rxSig_ff :
    (regAddr == `ADDR_RX_LEN_HI) ? rxLen_ff[15:8] :
    (regAddr == `ADDR_RX_LEN_LO) ? rxLen_ff[7:0] :
    (regAddr == `ADDR_RECEIVED_SERVICE_BYTE)    ? rxSer_ff :
    (regAddr == `ADDR_TX_GAIN)   ? txGain_ff :
    (regAddr == `ADDR_TX_LEN_HI) ? txLenHi_ff :
    (regAddr == `ADDR_TX_LEN_LO) ? txLenLo_ff :
    (regAddr == `ADDR_LOW_TRIM)  ? {2'b00, lowTrim_ff} :
    (regAddr == `ADDR_HIGH_TRIM) ? highTrim_ff :
    (regAddr == `ADDR_OPT1)      ? {satOffset_ff, optRetrig_ff, optAlt_ff, 3'b000} :
    (regAddr == `ADDR_OPT2)      ? {lnaDly_ff, 4'h0, retrigLow_ff, 2'b00} :
    `RST_BYTE;

  //////////////////////////////////////////////////////////////////////////////
  // Clear channel, antenna and gain loop control.
  wire logic rssiBusy = signalStrength >= cca_ff[5:0];
  wire logic nxtBusy  = cca_ff[7] ? (rssiBusy && acquiredFlag) :
                        cca_ff[6] ? acquiredFlag : rssiBusy;
  wire logic [2:0] nxtSat = satOffset_ff[2] ? (`SAT_BASE - {1'b0, satOffset_ff[1:0]}) :
                                              (`SAT_BASE + {1'b0, satOffset_ff[1:0]});

  logic [5:0] antDwell_ff;
  logic [4:0] stepCnt_ff;
  logic       extendPend_ff;
  logic       lnaPrev_ff;
  wire logic  divOn     = div_ff[1];
  wire logic  dwellDone = antDwell_ff == 6'd0;
  wire logic  lnaFall   = lnaPrev_ff && !pinSync[6];
  wire logic  stepDone  = stepCnt_ff == 5'd0;
  wire logic [4:0] nxtStep = extendPend_ff ? 5'((2 * `AGC_STEP_CYC) - 1) :
                                             5'(`AGC_STEP_CYC - 1);

  always_ff @(posedge refClk)
  begin
    if (reset)
    begin
      regRdData        <= `RST_BYTE;
      ccaBusy          <= 1'b0;
      antennaSelectPin <= 1'b0;
      antDwell_ff      <= 6'(`ANT_DWELL_CYC - 1);
      stepCnt_ff       <= 5'(`AGC_STEP_CYC - 1);
      extendPend_ff    <= 1'b0;
      lnaPrev_ff       <= 1'b0;
      agcDecision      <= 1'b0;
      saturationThreshold <= `SAT_BASE;
    end
    else
    begin
      regRdData   <= rdMux;
      ccaBusy     <= nxtBusy;
      lnaPrev_ff  <= pinSync[6];
      antDwell_ff <= (dwellDone || acquiredFlag) ? 6'(`ANT_DWELL_CYC - 1) : antDwell_ff - 6'd1;
      if (!divOn)
        antennaSelectPin <= div_ff[0];
      else if (dwellDone && !acquiredFlag)
        antennaSelectPin <= !antennaSelectPin;
      stepCnt_ff    <= stepDone ? nxtStep : stepCnt_ff - 5'd1;
      agcDecision   <= stepDone;
      extendPend_ff <= (lnaDly_ff && lnaFall) || (extendPend_ff && !stepDone);
      saturationThreshold <= nxtSat;
    end
  end

  assign txMode                     = mode_ff;
  assign transmitGainSetting        = txGain_ff[7:2];
  assign scramblerBypass            = txGain_ff[`GAIN_SCRAMBLE_BIT];
  assign transmitLengthExtensionBit = txGain_ff[`GAIN_EXT_BIT];
  assign lowGainTrim                = lowTrim_ff;
  assign highGainTrim               = highTrim_ff[5:0];
  assign sixDbPadBit                = highTrim_ff[`HIGH_PAD_BIT];
  assign channel14Filter            = highTrim_ff[`HIGH_CH14_BIT];
  assign saturationRetriggerBit     = optRetrig_ff;
  assign retriggerLowCount          = retrigLow_ff;

  //////////////////////////////////////////////////////////////////////////////
  // Transmit duration timer.
  tx_state_e   txState_ff;
  tx_state_e   nxtState;
  logic [15:0] usLeft_ff;
  logic [3:0]  subCnt_ff;
  logic        reqPrev_ff;
  wire logic [15:0] transmitLength = {txLenHi_ff, txLenLo_ff};
  wire logic txStart = pinSync[7] && !reqPrev_ff && (txState_ff == TX_IDLE);
  wire logic usTick  = subCnt_ff == 4'(`US_CYC - 1);
  wire logic lastUs  = usTick && (usLeft_ff == 16'd1);

  always_comb
  begin
    nxtState = txState_ff;
    case (txState_ff)
      TX_IDLE: if (txStart && (transmitLength != 16'd0)) nxtState = TX_RUN;
      TX_RUN:  if (lastUs) nxtState = TX_IDLE;
      default: nxtState = TX_IDLE;
    endcase
  end

  always_ff @(posedge refClk)
  begin
    if (reset)
    begin
      txState_ff <= TX_IDLE;
      txActive   <= 1'b0;
      usLeft_ff  <= 16'd0;
      subCnt_ff  <= 4'd0;
      reqPrev_ff <= 1'b0;
    end
    else
    begin
      txState_ff <= nxtState;
      txActive   <= nxtState == TX_RUN;
      reqPrev_ff <= pinSync[7];
      subCnt_ff  <= (txState_ff != TX_RUN || usTick) ? 4'd0 : subCnt_ff + 4'd1;
      if (txStart)
        usLeft_ff <= transmitLength;
      else if (usTick)
        usLeft_ff <= usLeft_ff - 16'd1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks.
  sequence s_len_start;
    txStart && (transmitLength == 16'd1);
  endsequence
  sequence s_one_us;
    txActive [*8] ##1 txActive ##1 txActive;
  endsequence

  a_tx_duration: assert property (@(posedge refClk) disable iff (reset)
    s_len_start |=> s_one_us ##1 !txActive)
    else $error("Transmit of one microsecond has wrong duration.");
  a_mode_write: assert property (@(posedge refClk) disable iff (reset)
    wrMode |=> txMode == $past(regWrData[7:4]))
    else $error("Mode nibble not taken from write.");
  a_status_read: assert property (@(posedge refClk) disable iff (reset)
    (regAddr == `ADDR_MODE) |=>
      regRdData[3:0] == $past({shortPreamble, acquiredFlag, delimiterFlag, rxCrc_ff}))
    else $error("Mode status bits do not show receiver state.");
  a_rssi_read: assert property (@(posedge refClk) disable iff (reset)
    (regAddr == `ADDR_DIV) |=> regRdData[5:0] == $past(signalStrength))
    else $error("Signal strength readback mismatch.");
  a_cca_rssi: assert property (@(posedge refClk) disable iff (reset)
    (cca_ff[7:6] == 2'b00) |=> ccaBusy == $past(signalStrength >= cca_ff[5:0]))
    else $error("Busy does not follow signal strength threshold.");
  a_ant_fixed: assert property (@(posedge refClk) disable iff (reset)
    !divOn |=> antennaSelectPin == $past(div_ff[0]))
    else $error("Antenna pin does not follow fixed antenna bit.");
  a_reserved_zero: assert property (@(posedge refClk) disable iff (reset)
    (regAddr == 8'h00 || regAddr == 8'h08 || regAddr == 8'h1e) |=> regRdData == 8'h00)
    else $error("Reserved address reads nonzero.");
  a_saturation_offset: assert property (@(posedge refClk) disable iff (reset)
    wrOpt1 && !regWrData[7] |-> ##2 saturationThreshold == 3'(4 + $past(regWrData[6:5], 2)))
    else $error("Saturation threshold not four plus offset.");
  a_lna_extend: assert property (@(posedge refClk) disable iff (reset)
    stepDone && extendPend_ff |=> stepCnt_ff == 5'd19 ##19 stepDone)
    else $error("Gain step not stretched to two microseconds.");
endmodule
`default_nettype wire

/* bench/host_model.sv */
`timescale 1ns/1ns
`default_nettype none
module host_model
  import modem_pkg::*;
(
  input  wire logic                 refClk,
  input  wire modem_pkg::reg_byte_t regRdData,
  output var  logic                 regWrEn,
  output var  modem_pkg::reg_addr_t regAddr,
  output var  modem_pkg::reg_byte_t regWrData
);
  initial
  begin
    regWrEn = 1'b0;
    regAddr = 8'h00;
    regWrData = 8'h00;
  end
  // Writes one byte; the strobe spans one rising edge and an idle edge follows.
  task automatic wr(input reg_addr_t a, input reg_byte_t d);
    regAddr = a;
    regWrData = d;
    regWrEn = 1'b1;
    @(posedge refClk);
    #5;
    regWrEn = 1'b0;
    regWrData = ~d;
    @(posedge refClk);
    #5;
  endtask
  // Reads one byte; the answer is registered one edge after the address.
  task automatic rd(input reg_addr_t a, output reg_byte_t d);
    regAddr = a;
    @(posedge refClk);
    #5;
    d = regRdData;
  endtask
endmodule
`default_nettype wire

/* bench/modem_control_regs_test.sv */
`timescale 1ns/1ns
`default_nettype none
`include "modem_cfg.svh"
module modem_control_regs_test;
  import modem_pkg::*;
  logic refClk = 1'b0, linkClk = 1'b0, reset = 1'b1;
  logic regWrEn, lnaGainSelectPin = 1'b0, txRequestPin = 1'b0, ccaBusy, antennaSelectPin;
  reg_addr_t regAddr;
  reg_byte_t regWrData, regRdData, hdrSignal = 8'h00, hdrService = 8'h00;
  logic [5:0] rssiPin = 6'h00, transmitGainSetting, lowGainTrim, highGainTrim;
  logic [3:0] txMode;
  logic [2:0] saturationThreshold;
  logic [15:0] hdrLength = 16'h0000;
  logic scramblerBypass, transmitLengthExtensionBit, txActive, sixDbPadBit, channel14Filter;
  logic saturationRetriggerBit, retriggerLowCount, agcDecision, dataBitClock, receiveValid;
  logic acqIn = 1'b0, sfdIn = 1'b0, shortPreIn = 1'b0, headerDone = 1'b0, hdrCrcErr = 1'b0;
  logic rxBitStrobe = 1'b0, receiveValidIn = 1'b0;
  int bad_count = 0, n_compared = 0;
  always #50 refClk = ~refClk;
  always #16 linkClk = ~linkClk;
  host_model i_host_model (.refClk(refClk), .regRdData(regRdData), .regWrEn(regWrEn),
    .regAddr(regAddr), .regWrData(regWrData));
  modem_control_regs i_modem_control_regs (.refClk(refClk), .reset(reset), .regWrEn(regWrEn),
    .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData), .rssiPin(rssiPin),
    .lnaGainSelectPin(lnaGainSelectPin), .txRequestPin(txRequestPin), .txMode(txMode),
    .ccaBusy(ccaBusy), .antennaSelectPin(antennaSelectPin),
    .transmitGainSetting(transmitGainSetting), .scramblerBypass(scramblerBypass),
    .transmitLengthExtensionBit(transmitLengthExtensionBit), .txActive(txActive),
    .lowGainTrim(lowGainTrim), .highGainTrim(highGainTrim), .sixDbPadBit(sixDbPadBit),
    .channel14Filter(channel14Filter), .saturationThreshold(saturationThreshold),
    .saturationRetriggerBit(saturationRetriggerBit), .retriggerLowCount(retriggerLowCount),
    .agcDecision(agcDecision), .linkClk(linkClk), .acqIn(acqIn), .sfdIn(sfdIn),
    .shortPreIn(shortPreIn), .headerDone(headerDone), .hdrSignal(hdrSignal),
    .hdrService(hdrService), .hdrLength(hdrLength), .hdrCrcErr(hdrCrcErr),
    .rxBitStrobe(rxBitStrobe), .receiveValidIn(receiveValidIn),
    .dataBitClock(dataBitClock), .receiveValid(receiveValid));
  ////////////////////////////////////////////////////////////////////////////////
  // Compares one value and counts it.
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_compared++;
    if (got !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic rc(input reg_addr_t a, input reg_byte_t exp);
    reg_byte_t d;
    i_host_model.rd(a, d);
    chk(d, exp, $sformatf("read %h", a));
  endtask
  task automatic waitc(input int n);
    repeat (n) @(posedge refClk);
    #5;
  endtask
  // Checks the port outputs after a link edge, then drives the next strobe and valid.
  task automatic link_step(input logic s, input logic v, input logic [1:0] e, input string m);
    @(posedge linkClk);
    #5;
    chk(8'({dataBitClock, receiveValid}), 8'(e), m);
    rxBitStrobe = s;
    receiveValidIn = v;
  endtask
  task automatic report_and_stop();
    if (bad_count == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Reset values of the writable registers and their outputs.
  task automatic t_reset();
    reg_addr_t al[10] = '{8'h01, 8'h02, 8'h03, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15, 8'h1c, 8'h1d};
    foreach (al[i]) rc(al[i], 8'h00);
    chk(8'(saturationThreshold), 8'h04, "sat reset");
    chk(8'(antennaSelectPin), 8'h00, "ant reset");
  endtask
  // Gain and trim fields drive their outputs; the gain and high trim bytes also read back.
  task automatic t_rw();
    i_host_model.wr(8'h11, 8'ha6);
    i_host_model.wr(8'h15, 8'hc5);
    i_host_model.wr(8'h14, 8'h3f);
    rc(8'h11, 8'ha6);
    rc(8'h15, 8'hc5);
    chk(8'(transmitGainSetting), 8'h29, "gain");
    chk({6'h00, scramblerBypass, transmitLengthExtensionBit}, 8'h02, "scr");
    chk({channel14Filter, sixDbPadBit, highGainTrim}, 8'hc5, "high");
    chk(8'(lowGainTrim), 8'h3f, "low");
  endtask
  // Mode nibble is writable; the four status bits ignore writes.
  task automatic t_mode();
    acqIn = 1'b1;
    shortPreIn = 1'b1;
    i_host_model.wr(8'h01, 8'h7f);
    waitc(4);
    chk(8'(txMode), 8'h07, "mode");
    rc(8'h01, 8'h7c);
    sfdIn = 1'b1;
    waitc(4);
    rc(8'h01, 8'h7e);
  endtask
  // Busy decision, antenna select and the signal strength readback.
  task automatic t_cca();
    rssiPin = 6'h2a;
    i_host_model.wr(8'h02, 8'h2a);
    waitc(4);
    chk(8'(ccaBusy), 8'h01, "busy eq");
    i_host_model.wr(8'h02, 8'h2b);
    waitc(4);
    chk(8'(ccaBusy), 8'h00, "busy below");
    i_host_model.wr(8'h02, 8'h7f);
    waitc(4);
    chk(8'(ccaBusy), 8'h01, "busy acq");
    acqIn = 1'b0;
    waitc(4);
    chk(8'(ccaBusy), 8'h00, "busy noacq");
    i_host_model.wr(8'h02, 8'hc0);
    waitc(4);
    chk(8'(ccaBusy), 8'h00, "busy both off");
    acqIn = 1'b1;
    waitc(4);
    chk(8'(ccaBusy), 8'h01, "busy both");
    i_host_model.wr(8'h02, 8'hff);
    waitc(4);
    chk(8'(ccaBusy), 8'h00, "busy both low");
    acqIn = 1'b0;
    i_host_model.wr(8'h03, 8'h7f);
    rc(8'h03, 8'h6a);
    chk(8'(antennaSelectPin), 8'h01, "ant fixed");
  endtask
  task automatic ant_toggles(output int n);
    logic p;
    n = 0;
    repeat (80)
    begin
      p = antennaSelectPin;
      waitc(1);
      if (antennaSelectPin !== p)
        n++;
    end
  endtask
  // Diversity hunts between antennas until acquisition, then holds.
  task automatic t_div();
    int n;
    i_host_model.wr(8'h03, 8'h80);
    ant_toggles(n);
    chk(8'(n), 8'd2, "ant hunt");
    acqIn = 1'b1;
    waitc(4);
    ant_toggles(n);
    chk(8'(n), 8'd0, "ant hold");
    acqIn = 1'b0;
    i_host_model.wr(8'h03, 8'h00);
    chk(8'(antennaSelectPin), 8'h00, "ant zero");
  endtask
  // A header with a bad check crosses from the link clock.
  task automatic t_header();
    sfdIn = 1'b0;
    shortPreIn = 1'b0;
    @(posedge linkClk);
    #5;
    {hdrSignal, hdrService, hdrLength, hdrCrcErr, headerDone} = {32'h6e88_1234, 2'b11};
    @(posedge linkClk);
    #5;
    headerDone = 1'b0;
    waitc(8);
    rc(8'h04, 8'h6e);
    rc(8'h05, 8'h12);
    rc(8'h06, 8'h34);
    rc(8'h07, 8'h88);
    rc(8'h01, 8'h71);
  endtask
  // One request; counts the cycles for which the transmitter stays on.
  task automatic tx_once(input reg_byte_t len, output int n);
    i_host_model.wr(8'h13, len);
    txRequestPin = 1'b1;
    for (n = 0; n < 10 && txActive !== 1'b1; n++) waitc(1);
    for (n = 0; n < 100 && txActive === 1'b1; n++) waitc(1);
    txRequestPin = 1'b0;
    waitc(2);
  endtask
  // Transmissions of two, one and zero microseconds.
  task automatic t_tx();
    int n;
    i_host_model.wr(8'h12, 8'h00);
    tx_once(8'h02, n);
    chk(8'(n), 8'd20, "tx length");
    tx_once(8'h01, n);
    chk(8'(n), 8'd10, "tx one");
    tx_once(8'h00, n);
    chk(8'(n), 8'd0, "tx zero");
  endtask
  // Option bits and reserved addresses.
  task automatic t_opts();
    i_host_model.wr(8'h1c, 8'hb8);
    rc(8'h1c, 8'hb8);
    chk({4'h0, saturationRetriggerBit, saturationThreshold}, 8'h0b, "opt1");
    i_host_model.wr(8'h1c, 8'h60);
    chk(8'(saturationThreshold), 8'h07, "sat plus");
    i_host_model.wr(8'h1d, 8'h84);
    chk(8'(retriggerLowCount), 8'h01, "retrig");
    i_host_model.wr(8'h08, 8'hff);
    rc(8'h08, 8'h00);
    rc(8'h1e, 8'h00);
  endtask
  // Receive data port in the normal and the alternate variant.
  task automatic t_link();
    link_step(1'b1, 1'b1, 2'b00, "port idle");
    link_step(1'b0, 1'b1, 2'b11, "bit clock");
    link_step(1'b0, 1'b0, 2'b01, "bit done");
    link_step(1'b0, 1'b0, 2'b00, "no extra");
    i_host_model.wr(8'h1c, 8'h08);
    waitc(2);
    link_step(1'b1, 1'b1, 2'b10, "alt idle");
    link_step(1'b0, 1'b1, 2'b01, "alt bit");
    link_step(1'b0, 1'b0, 2'b11, "alt done");
    link_step(1'b0, 1'b0, 2'b00, "alt extra");
    link_step(1'b0, 1'b0, 2'b10, "alt end");
  endtask
  task automatic gap(output int n);
    for (n = 1; n < 40; n++)
    begin
      waitc(1);
      if (agcDecision === 1'b1)
        break;
    end
  endtask
  // A falling gain-select pin with the delay option set stretches the following step.
  task automatic t_agc();
    int n;
    lnaGainSelectPin = 1'b1;
    gap(n);
    gap(n);
    chk(8'(n), 8'd10, "agc step");
    lnaGainSelectPin = 1'b0;
    gap(n);
    gap(n);
    chk(8'(n), 8'd20, "agc stretch");
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (4) @(posedge refClk);
    #5;
    reset = 1'b0;
    @(posedge refClk);
    #5;
    t_reset();
    t_rw();
    t_mode();
    t_cca();
    t_div();
    t_header();
    t_tx();
    t_opts();
    t_link();
    t_agc();
    report_and_stop();
  end
  initial
  begin
    #200000;
    bad_count++;
    report_and_stop();
  end
endmodule
`default_nettype wire
